// >>> gpi_and_random_source_test.sv
`include "grs_defs.svh"

module gpi_and_random_source_test import grs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_PIN = `GRS_IDX_PIN_SNAPSHOT << 2;
  localparam logic [31:0] A_HW  = `GRS_IDX_HW_STATUS << 2;
  localparam logic [31:0] A_DS  = `GRS_IDX_DATA_STATUS << 2;
  localparam logic [31:0] A_DAT = `GRS_IDX_DATA_BYTE << 2;
  localparam logic [31:0] A_IS  = `GRS_IDX_IRQ_STATUS << 2;
  localparam logic [31:0] A_IM  = `GRS_IDX_IRQ_MASK << 2;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        noise = 1'b0;
  logic [4:0]  pins = 5'h00;
  logic        psel, pen, pwr, prdy, perr, irq, lp, e;
  logic [31:0] padr, pwd, prd, q;
  logic [3:0]  pst;
  int          fails = 0;
  int          n_tests = 0;
  int          n;
  // Clock and entropy stimulus
  always #5 clk = ~clk;
  always @(posedge clk) noise <= ~noise ^ pins[0];
  grs_host_model host (.clk_i(clk), .pready_i(prdy), .pslverr_i(perr), .prdata_i(prd), .psel_o(psel),
    .penable_o(pen), .pwrite_o(pwr), .paddr_o(padr), .pwdata_o(pwd), .pstrb_o(pst));
  grs_random_source dut (.core_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(padr), .pwdata_i(pwd), .pstrb_i(pst), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .general_purpose_input_pins_i(pins), .noise_bit_i(noise), .irq_o(irq), .low_power_o(lp));
  task automatic print_verdict();
    if (host.hung) fails++;
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h00000000, q, e);
    if (host.hung) print_verdict();
    check(q, exp);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
    if (host.hung) print_verdict();
  endtask
  // Reset values and pin pass-through
  task automatic t_regs();
    rd(A_HW, 32'h00000040);
    rd(A_DS, 32'h00000000);
    rd(A_DAT, 32'h00000040);
    rd(A_IM, 32'h00000000);
    pins <= 5'h15;
    rd(A_PIN, 32'h00000015);
    wr(A_PIN, 32'h000000FF);
    pins <= 5'h0A;
    rd(A_PIN, 32'h0000000A);
    wr(A_HW, 32'h000000FE);
    rd(A_HW, 32'h00000040);
    rd(32'h00000010, 32'h00000000);
    check({31'h0, e}, 32'h00000001);
  endtask
  // Byte assembly, valid flag, interrupt
  task automatic t_random();
    wr(A_IM, 32'h00000001);
    rd(A_HW, 32'h00000040);
    wr(A_HW, 32'h00000001);
    wr(A_DAT, 32'h00000000);
    host.xfer(1'b0, A_DAT, 32'h00000000, q, e);
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (irq === 1'b1) break;
    end
    check(n >= 20 && n <= 40, 32'h00000001);
    check({31'h0, lp}, 32'h00000001);
    rd(A_DS, 32'h00000001);
    host.xfer(1'b0, A_DAT, 32'h00000000, q, e);
    rd(A_DS, 32'h00000000);
    check({31'h0, lp}, 32'h00000000);
    wr(A_IS, 32'h00000001);
    rd(A_IS, 32'h00000000);
    check({31'h0, irq}, 32'h00000000);
    wr(A_IM, 32'h00000000);
    repeat (45) @(posedge clk);
    check({31'h0, irq}, 32'h00000000);
    rd(A_IS, 32'h00000001);
    wr(A_HW, 32'h00000000);
    rd(A_HW, 32'h00000040);
    check({31'h0, lp}, 32'h00000001);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_random();
    print_verdict();
  end
endmodule

// >>> grs_checker.sv
`include "grs_defs.svh"

module grs_checker (
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [4:0]  general_purpose_input_pins_i,
  input wire logic        low_power_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_PIN = `GRS_IDX_PIN_SNAPSHOT << 2;
  localparam logic [31:0] A_HW  = `GRS_IDX_HW_STATUS << 2;
  localparam logic [31:0] A_DS  = `GRS_IDX_DATA_STATUS << 2;
  // Read completion
  wire rd = pready_o && !pwrite_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_setup; psel_i && !penable_i ##1 psel_i && penable_i; endsequence
  sequence s_answer; !pready_o ##1 pready_o; endsequence
  property p_wait; s_setup |-> s_answer; endproperty
  a_wait: assert property (p_wait) else $error("answer not after one wait state");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_upper; pready_o |-> prdata_o[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_pins; rd && paddr_i == A_PIN |-> prdata_o[7:0] == {3'h0, $past(general_purpose_input_pins_i)}; endproperty
  a_pins: assert property (p_pins) else $error("pin snapshot mismatch");
  property p_hw; rd && paddr_i == A_HW |-> prdata_o[7:1] == 7'h20; endproperty
  a_hw: assert property (p_hw) else $error("hardware status fields wrong");
  property p_ds; rd && paddr_i == A_DS |-> prdata_o[7:1] == 7'h00; endproperty
  a_ds: assert property (p_ds) else $error("data status reserved bits set");
  property p_sleep;
    pready_o && pwrite_i && paddr_i == A_HW && pstrb_i[0] && !pwdata_i[0] |-> ##[1:2] low_power_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no low power after disable");
  property p_err; pslverr_o |-> pready_o && (pwrite_i || prdata_o == 32'h00000000); endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
endmodule

bind grs_random_source grs_checker u_chk (.core_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .general_purpose_input_pins_i, .low_power_o);

// >>> grs_defs.svh
`ifndef GRS_DEFS_SVH
`define GRS_DEFS_SVH

// Register indices; byte address is four times the index
`define GRS_IDX_PIN_SNAPSHOT   32'hFFBC0100
`define GRS_IDX_HW_STATUS      32'hFFBC015F
`define GRS_IDX_DATA_STATUS    32'hFFBC0160
`define GRS_IDX_DATA_BYTE      32'hFFBC0161
`define GRS_IDX_IRQ_STATUS     32'hFFBC0170
`define GRS_IDX_IRQ_MASK       32'hFFBC0171

// Field positions
`define GRS_HW_PRESENT_BIT     6
`define GRS_HW_ENABLE_BIT      0
`define GRS_DS_VALID_BIT       0
`define GRS_IRQ_READY_BIT      0
`define GRS_PIN_COUNT          5

// Reset values
`define GRS_RST_HW_STATUS      8'h40
`define GRS_RST_DATA_STATUS    8'h00
`define GRS_RST_DATA_BYTE      8'h40
`define GRS_RST_IRQ_MASK       8'h00
`define GRS_RST_LFSR           16'hACE1

// Timing: one random bit every this many nanoseconds
`define GRS_BIT_PERIOD_NS      40
`define GRS_CLK_PERIOD_NS      10
`define GRS_BIT_DIV            (`GRS_BIT_PERIOD_NS / `GRS_CLK_PERIOD_NS)

`endif

// >>> grs_host_model.sv
module grs_host_model (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [31:0] paddr_o,
  output logic      [31:0] pwdata_o,
  output logic      [3:0]  pstrb_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hung = 1'b0;
  // Idle bus at time zero
  initial begin
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = '0;
  end
  // One transfer: setup, access held until ready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    pstrb_o <= 4'hF;
    @(posedge clk_i);
    penable_o <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (pready_i === 1'b1) break;
    end
    if (n == 20) hung = 1'b1;
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// >>> grs_pkg.sv
package grs_pkg;

  // APB request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } grs_apb_req_type;

  // Generator activity
  typedef enum logic [1:0] {
    GRS_SLEEP,
    GRS_FILL,
    GRS_FULL
  } grs_gen_state_type;

  // Register select decoded from an address
  typedef enum logic [2:0] {
    GRS_SEL_PINS,
    GRS_SEL_HW,
    GRS_SEL_DSTAT,
    GRS_SEL_DATA,
    GRS_SEL_ISTAT,
    GRS_SEL_IMASK,
    GRS_SEL_NONE
  } grs_sel_type;

endpackage

// >>> grs_random_source.sv
`include "grs_defs.svh"

module grs_random_source
  import grs_pkg::*;
#(
  parameter int          BIT_DIV     = `GRS_BIT_DIV,
  parameter logic        GEN_PRESENT = 1'b1,
  parameter logic [15:0] LFSR_SEED   = `GRS_RST_LFSR
) (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [4:0]  general_purpose_input_pins_i,
  input  wire logic        noise_bit_i,
  output logic             irq_o,
  output logic             low_power_o
);

  localparam int DIV_W = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

  // Reset images of the registers, so single bits can be picked out
  localparam logic [7:0] RST_HW_STATUS   = `GRS_RST_HW_STATUS;
  localparam logic [7:0] RST_DATA_STATUS = `GRS_RST_DATA_STATUS;
  localparam logic [7:0] RST_IRQ_MASK    = `GRS_RST_IRQ_MASK;

  grs_apb_req_type   req;
  grs_sel_type       sel;
  grs_gen_state_type state_r;
  logic              enable_r;
  logic              valid_r;
  logic [7:0]        hold_r;
  logic [7:0]        data_r;
  logic [2:0]        bit_cnt_r;
  logic [DIV_W-1:0]  div_r;
  logic              bit_tick;
  logic [15:0]       lfsr_r;
  logic              fresh_bit;
  logic              byte_done;
  logic              xfer_done;
  logic              wr_ok;
  logic              data_read;
  logic [7:0]        irq_stat_r;
  logic [7:0]        irq_mask_r;
  logic [7:0]        rd_byte;
  logic              ans_start;
  logic              hw_wr;
  logic              istat_wr;
  logic              imask_wr;
  logic [7:0]        irq_event;

  // Decode of a word address onto a register select
  function automatic grs_sel_type grs_decode(input logic [31:0] addr);
    logic [29:0] idx;
    idx = addr[31:2];
    if (idx == 30'(`GRS_IDX_PIN_SNAPSHOT)) begin
      return GRS_SEL_PINS;
    end else if (idx == 30'(`GRS_IDX_HW_STATUS)) begin
      return GRS_SEL_HW;
    end else if (idx == 30'(`GRS_IDX_DATA_STATUS)) begin
      return GRS_SEL_DSTAT;
    end else if (idx == 30'(`GRS_IDX_DATA_BYTE)) begin
      return GRS_SEL_DATA;
    end else if (idx == 30'(`GRS_IDX_IRQ_STATUS)) begin
      return GRS_SEL_ISTAT;
    end else if (idx == 30'(`GRS_IDX_IRQ_MASK)) begin
      return GRS_SEL_IMASK;
    end else begin
      return GRS_SEL_NONE;
    end
  endfunction

  // Strobe qualified by a register select; shared by every write and read side effect
  function automatic logic grs_hit(input logic        strobe,
                                   input grs_sel_type got,
                                   input grs_sel_type want);
    return strobe && (got == want);
  endfunction

  // Bundle the bus and decode it once
  assign req       = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                       paddr: paddr_i, pwdata: pwdata_i, pstrb: pstrb_i};
  assign sel       = grs_decode(req.paddr);
  assign xfer_done = req.psel & req.penable & pready_o;
  assign wr_ok     = xfer_done & req.pwrite & req.pstrb[0] & (sel != GRS_SEL_NONE);
  assign data_read = grs_hit(xfer_done & ~req.pwrite, sel, GRS_SEL_DATA);

  // Per-register write strobes; read-only registers have none
  assign hw_wr     = grs_hit(wr_ok, sel, GRS_SEL_HW);
  assign istat_wr  = grs_hit(wr_ok, sel, GRS_SEL_ISTAT);
  assign imask_wr  = grs_hit(wr_ok, sel, GRS_SEL_IMASK);

  // Read data mux; reserved bits are zero
  always_comb begin
    rd_byte = 8'h00;
    case (sel)
      GRS_SEL_PINS: begin
        rd_byte = {3'b000, general_purpose_input_pins_i};
      end
      GRS_SEL_HW: begin
        rd_byte = 8'h00;
        rd_byte[`GRS_HW_PRESENT_BIT] = GEN_PRESENT;
        rd_byte[`GRS_HW_ENABLE_BIT]  = enable_r;
      end
      GRS_SEL_DSTAT: begin
        rd_byte = 8'h00;
        rd_byte[`GRS_DS_VALID_BIT] = valid_r;
      end
      GRS_SEL_DATA: begin
        rd_byte = data_r;
      end
      GRS_SEL_ISTAT: begin
        rd_byte = irq_stat_r;
      end
      GRS_SEL_IMASK: begin
        rd_byte = irq_mask_r;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // First access cycle of a request; the answer follows one edge later
  assign ans_start = req.psel & req.penable & ~pready_o;

  // Ready pulse: one wait state, high in the second access cycle only
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= ans_start;
    end
  end

  // Error answer for unmapped addresses, raised together with ready
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= ans_start && (sel == GRS_SEL_NONE);
    end
  end

  // Read data; held between answers, zero on writes and unmapped reads
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (ans_start) begin
      prdata_o <= req.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
  end

  // Enable bit; a missing generator cannot be enabled
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      enable_r <= RST_HW_STATUS[`GRS_HW_ENABLE_BIT];
    end else if (hw_wr) begin
      enable_r <= req.pwdata[`GRS_HW_ENABLE_BIT] & GEN_PRESENT;
    end
  end

  // Bit-rate divider; held at zero outside the fill state
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      div_r <= '0;
    end else if (state_r != GRS_FILL) begin
      div_r <= '0;
    end else if (div_r == DIV_W'(BIT_DIV - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  assign bit_tick  = (state_r == GRS_FILL) && (div_r == DIV_W'(BIT_DIV - 1));
  assign fresh_bit = lfsr_r[0] ^ noise_bit_i;
  assign byte_done = bit_tick && (bit_cnt_r == 3'd7);

  // Whitening register stirred with the noise input, advanced only per bit
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      lfsr_r <= LFSR_SEED;
    end else if (bit_tick) begin
      lfsr_r <= {lfsr_r[0] ^ lfsr_r[2] ^ lfsr_r[3] ^ lfsr_r[5] ^ noise_bit_i, lfsr_r[15:1]};
    end
  end

  // Generator state: fill while enabled, full when a byte completes, sleep when disabled
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= GRS_SLEEP;
    end else begin
      case (state_r)
        GRS_SLEEP: begin
          if (enable_r) begin
            state_r <= GRS_FILL;
          end
        end
        GRS_FILL: begin
          if (!enable_r) begin
            state_r <= GRS_SLEEP;
          end else if (byte_done) begin
            state_r <= GRS_FULL;
          end
        end
        GRS_FULL: begin
          if (!enable_r) begin
            state_r <= GRS_SLEEP;
          end else if (data_read) begin
            state_r <= GRS_FILL;
          end
        end
        default: begin
          state_r <= GRS_SLEEP;
        end
      endcase
    end
  end

  // Shift one random bit per tick into the holding register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      hold_r <= 8'h00;
    end else if (bit_tick) begin
      hold_r <= {hold_r[6:0], fresh_bit};
    end
  end

  // Bit counter; kept across a disable so a partial byte resumes
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      bit_cnt_r <= 3'd0;
    end else if (bit_tick) begin
      bit_cnt_r <= bit_cnt_r + 3'd1; // wraps after the eighth bit
    end
  end

  // Data byte loads when full
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      data_r <= `GRS_RST_DATA_BYTE;
    end else if (byte_done) begin
      data_r <= {hold_r[6:0], fresh_bit};
    end
  end

  // Valid flag; completion wins over a same-cycle read
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      valid_r <= RST_DATA_STATUS[`GRS_DS_VALID_BIT];
    end else if (byte_done) begin
      valid_r <= 1'b1;
    end else if (data_read) begin
      valid_r <= 1'b0;
    end
  end

  // Events feeding the sticky status bits; only byte-ready is in use
  always_comb begin
    irq_event = 8'h00;
    irq_event[`GRS_IRQ_READY_BIT] = byte_done;
  end

  // Sticky status bits, write one to clear; a same-cycle event wins
  // so a byte finishing during the clear is never lost
  for (genvar gi = 0; gi < 8; gi++) begin : g_irq_bit
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        irq_stat_r[gi] <= 1'b0;
      end else if (irq_event[gi]) begin
        irq_stat_r[gi] <= 1'b1;
      end else if (istat_wr && req.pwdata[gi]) begin
        irq_stat_r[gi] <= 1'b0;
      end
    end
  end

  // Interrupt mask, only the used bit is writable
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      irq_mask_r <= RST_IRQ_MASK;
    end else if (imask_wr) begin
      irq_mask_r[`GRS_IRQ_READY_BIT] <= req.pwdata[`GRS_IRQ_READY_BIT];
    end
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Low-power indication: asleep or holding a full byte
  // lets the supply logic gate the noise source between bytes
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      low_power_o <= 1'b1;
    end else begin
      low_power_o <= (state_r != GRS_FILL);
    end
  end

endmodule
